// ### hdl/fpx_pkg.sv
// Package with constants and types shared by the flash and data RAM sequencer ends.
// Contract
// - Write enable redirects move writes to flash.
// - Erase plus write enable erases whole page.
// - Write enable clear: moves reach RAM only.
// - Control bits 7..2 read zero, ignore writes.
// - Software erases before programming a byte.
// - Flash locked until keys A5 then F1.
// - One operation per unlock, then relock.
// - Wrong key or early attempt disables until reset.
// - Key read returns lock state bits 1..0.
// - One-shot bit selects pulsed or full sensing.
// - Scale bits 6..0 read zero; resets 0x80.
// - User RAM low 1k, FIFO high 1k.
// - Upper five address bits ignored, aliasing 2k.
// - Page field supplies high byte for 8-bit moves.
// - FIFO region accesses take extra cycles.
// - Software avoids moving packet data via moves.
// - Supply monitor off on modify: error reset.
// - Error reset flag reads one after reset.
`default_nettype none
package fpx_pkg;
  localparam logic [7:0]  ADDR_PSC     = 8'h8F;
  localparam logic [7:0]  ADDR_PAGE    = 8'hAA;
  localparam logic [7:0]  ADDR_SCALE   = 8'hB6;
  localparam logic [7:0]  ADDR_KEY     = 8'hB7;
  localparam logic [7:0]  RST_PSC      = 8'h00;
  localparam logic [7:0]  RST_PAGE     = 8'h00;
  localparam logic [7:0]  RST_SCALE    = 8'h80;
  localparam logic [7:0]  KEY_FIRST    = 8'hA5;
  localparam logic [7:0]  KEY_SECOND   = 8'hF1;
  localparam int          BIT_WE       = 0;
  localparam int          BIT_EE       = 1;
  localparam int          BIT_OSE      = 7;
  localparam int          PAGE_W       = 3;
  localparam int          RAM_AW       = 11;
  localparam int          RAM_DEPTH    = 2048;
  localparam int          FLASH_AW     = 14;
  localparam int          FLASH_PAGE_AW = 9;
  localparam logic [3:0]  PROG_CYCLES  = 4'h8;
  localparam logic [3:0]  ERASE_CYCLES = 4'hF;
  localparam logic [3:0]  FIFO_CYCLES  = 4'h3;
  localparam logic [1:0]  LK_LOCKED    = 2'h0;
  localparam logic [1:0]  LK_FIRST     = 2'h1;
  localparam logic [1:0]  LK_OPEN      = 2'h2;
  localparam logic [1:0]  LK_DEAD      = 2'h3;
  localparam logic [31:0] APB_CTRL     = 32'h0000_0000;
  localparam logic [31:0] APB_STATUS   = 32'h0000_0004;
  localparam logic [31:0] APB_EVT      = 32'h0000_0008;
  localparam logic [31:0] APB_MASK     = 32'h0000_000C;
  localparam logic [31:0] APB_RDATA    = 32'h0000_0010;
  localparam int          EVT_DONE     = 0;
  localparam int          EVT_FERR     = 1;
  typedef enum logic [2:0] {
    OP_NONE, OP_SFR_WR, OP_SFR_RD, OP_MOVE_WR, OP_MOVE_RD
  } fpx_op_type;
endpackage
`default_nettype wire

// ### hdl/fpx_link_if.sv
// Interface joining the core-side controller and the sequencer device.
`default_nettype none
interface fpx_link_if;
  logic        req;
  logic [2:0]  op;
  logic [15:0] addr;
  logic        addr8;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  logic        stall;
  logic        sense_pulse;
  logic        ferr_reset;
  modport device (input req, op, addr, addr8, wdata, output done, rdata, stall, sense_pulse, ferr_reset);
  modport core (output req, op, addr, addr8, wdata, input done, rdata, stall, sense_pulse, ferr_reset);
endinterface
`default_nettype wire

// ### hdl/fpx_lock.sv
// Two-code key lock for flash modification.
`default_nettype none
module fpx_lock
  import fpx_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       op_try,
  output logic [1:0]      lock_state
);
  logic [1:0] next_state;
  always_comb begin
    next_state = lock_state;
    if (lock_state != LK_DEAD) begin
      if (op_try) begin
        next_state = (lock_state == LK_OPEN) ? LK_LOCKED : LK_DEAD;
      end else if (key_wr) begin
        case (lock_state)
          LK_LOCKED: next_state = (key_data == KEY_FIRST) ? LK_FIRST : LK_DEAD;
          LK_FIRST:  next_state = (key_data == KEY_SECOND) ? LK_OPEN : LK_DEAD;
          default:   next_state = LK_DEAD; // Extra key writes while open count as wrong codes.
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) lock_state <= LK_LOCKED;
    else lock_state <= next_state;
  end
endmodule // fpx_lock
`default_nettype wire

// ### hdl/fpx_device.sv
// Sequencer device: special registers, data RAM, flash program and erase.
//
// Register access over APB was chosen for this implementation.
`default_nettype none
module fpx_device
  import fpx_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  resetn,
  fpx_link_if.device lnk,
  input  wire logic  supply_ok,
  input  wire logic  flash_error_reset_flag_in,
  output logic       flash_error_reset_flag,
  output logic [1:0] lock_state_out,
  output logic       flash_busy
);
  typedef enum {S_IDLE, S_WAIT, S_DONE} fpx_st_type;
  fpx_st_type state;
  logic [7:0]  psc, page, scale;
  logic [7:0]  ram [RAM_DEPTH];
  logic [7:0]  flash [1 << FLASH_AW];
  logic [3:0]  cnt;
  logic [7:0]  rdata, rbyte;
  logic        done, sense, ferr, is_erase, dowrite;
  logic [15:0] lat_addr;
  logic [1:0]  lock_state;
  logic        first_cycle;
  wire logic        start     = lnk.req && state == S_IDLE;
  wire logic        sfr_wr    = start && fpx_op_type'(lnk.op) == OP_SFR_WR;
  wire logic        mv_wr     = start && fpx_op_type'(lnk.op) == OP_MOVE_WR;
  wire logic        mv_rd     = start && fpx_op_type'(lnk.op) == OP_MOVE_RD;
  wire logic [15:0] eff_addr  = lnk.addr8 ? {5'h00, page[PAGE_W-1:0], lnk.addr[7:0]} : lnk.addr;
  wire logic [RAM_AW-1:0] ram_a = eff_addr[RAM_AW-1:0];
  wire logic        to_flash  = mv_wr && psc[BIT_WE];
  wire logic        flash_ok  = to_flash && lock_state == LK_OPEN && supply_ok;
  wire logic        fifo_hit  = ram_a[RAM_AW-1];
  wire logic        key_wr    = sfr_wr && lnk.addr[7:0] == ADDR_KEY;
  wire logic [7:0]  sfr_rd    = (lnk.addr[7:0] == ADDR_PSC)   ? {6'h00, psc[1:0]} :
                                (lnk.addr[7:0] == ADDR_PAGE)  ? {5'h00, page[2:0]} :
                                (lnk.addr[7:0] == ADDR_SCALE) ? {scale[7], 7'h00} :
                                (lnk.addr[7:0] == ADDR_KEY)   ? {6'h00, lock_state} : 8'h00;
  fpx_lock u_lock (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .key_wr     (key_wr),
    .key_data   (lnk.wdata),
    .op_try     (to_flash && supply_ok),
    .lock_state (lock_state)
  );
  assign lnk.done        = done;
  assign lnk.rdata       = rdata;
  assign lnk.stall       = flash_busy;
  assign lnk.sense_pulse = sense;
  assign lnk.ferr_reset  = ferr;
  assign lock_state_out  = lock_state;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      psc   <= RST_PSC;
      page  <= RST_PAGE;
      scale <= RST_SCALE;
    end else if (sfr_wr) begin
      if (lnk.addr[7:0] == ADDR_PSC)   psc   <= {6'h00, lnk.wdata[1:0]};
      if (lnk.addr[7:0] == ADDR_PAGE)  page  <= {5'h00, lnk.wdata[2:0]};
      if (lnk.addr[7:0] == ADDR_SCALE) scale <= {lnk.wdata[BIT_OSE], 7'h00};
    end
  end
  // The error flag is captured clocked after release, since async reset may only load constants.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) first_cycle <= 1'b1;
    else first_cycle <= 1'b0;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) flash_error_reset_flag <= 1'b0;
    else if (first_cycle) flash_error_reset_flag <= flash_error_reset_flag_in;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_busy <= 1'b0;
      ferr <= 1'b0;
      sense <= 1'b0;
      is_erase <= 1'b0;
      dowrite <= 1'b0;
      lat_addr <= 16'h0000;
    end else begin
      done <= 1'b0;
      sense <= 1'b0;
      dowrite <= 1'b0;
      ferr <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            lat_addr <= eff_addr;
            if (to_flash && !supply_ok) begin
              ferr <= 1'b1;
              done <= 1'b1;
            end else if (flash_ok) begin
              is_erase <= psc[BIT_EE];
              flash_busy <= 1'b1;
              cnt <= psc[BIT_EE] ? ERASE_CYCLES : PROG_CYCLES;
              state <= S_WAIT;
            end else if ((mv_wr || mv_rd) && !to_flash && fifo_hit) begin
              cnt <= FIFO_CYCLES;
              state <= S_WAIT;
            end else begin
              rdata <= mv_rd ? rbyte : sfr_rd;
              sense <= mv_rd;
              done <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          cnt <= cnt - 4'h1;
          sense <= scale[BIT_OSE] ? 1'b0 : 1'b1;
          if (cnt == 4'h1) state <= S_DONE;
        end
        S_DONE: begin
          rdata <= rbyte;
          dowrite <= !flash_busy && lnk.op == OP_MOVE_WR;
          flash_busy <= 1'b0;
          done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  assign rbyte = ram[(state == S_IDLE) ? ram_a : lat_addr[RAM_AW-1:0]];
  // Storage holds no reset; flash starts erased only after an explicit page erase.
  // One process owns the flash array, so program and erase never drive it from two places.
  always_ff @(posedge core_clk) begin
    if (mv_wr && !to_flash && !fifo_hit) ram[ram_a] <= lnk.wdata;
    if (dowrite) ram[lat_addr[RAM_AW-1:0]] <= lnk.wdata;
    if (state == S_DONE && flash_busy && !is_erase)
      flash[lat_addr[FLASH_AW-1:0]] <= flash[lat_addr[FLASH_AW-1:0]] & lnk.wdata;
    if (state == S_DONE && flash_busy && is_erase) begin
      for (int j = 0; j < (1 << FLASH_PAGE_AW); j++) begin
        flash[{lat_addr[FLASH_AW-1:FLASH_PAGE_AW], j[FLASH_PAGE_AW-1:0]}] <= 8'hFF;
      end
    end
  end
endmodule // fpx_device
`default_nettype wire

// ### hdl/fpx_core.sv
// Core-side end: APB registers issue one move or register access on the link.
`default_nettype none
module fpx_core
  import fpx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  fpx_link_if.core         lnk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  logic [31:0] ctrl;
  logic [7:0]  rd;
  logic [1:0]  evt, mask;
  logic        busy, req;
  wire logic acc   = psel && penable && !pready;
  wire logic wr    = acc && pwrite;
  wire logic hit   = paddr == APB_CTRL || paddr == APB_STATUS || paddr == APB_EVT ||
                     paddr == APB_MASK || paddr == APB_RDATA;
  wire logic go    = wr && paddr == APB_CTRL && !busy;
  wire logic [1:0] set_e = {lnk.ferr_reset, lnk.done};
  wire logic [31:0] rsel = (paddr == APB_CTRL)   ? ctrl :
                           (paddr == APB_STATUS) ? {29'h0, lnk.stall, busy, 1'b0} :
                           (paddr == APB_EVT)    ? {30'h0, evt} :
                           (paddr == APB_MASK)   ? {30'h0, mask} :
                           (paddr == APB_RDATA)  ? {24'h0, rd} : 32'h0;
  assign lnk.req   = req;
  assign lnk.op    = ctrl[26:24];
  assign lnk.addr8 = ctrl[27];
  assign lnk.addr  = ctrl[23:8];
  assign lnk.wdata = ctrl[7:0];
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready <= acc;
      pslverr <= acc && !hit;
      prdata <= acc ? rsel : 32'h0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= 32'h0; req <= 1'b0; busy <= 1'b0; rd <= 8'h00; mask <= 2'h0; evt <= 2'h0; irq <= 1'b0;
    end else begin
      if (go) begin ctrl <= pwdata; req <= 1'b1; busy <= 1'b1; end
      else req <= 1'b0;
      if (lnk.done) begin busy <= 1'b0; rd <= lnk.rdata; end
      if (wr && paddr == APB_MASK) mask <= pwdata[1:0];
      // A new event wins over a write-one clear in the same cycle.
      evt <= (evt & ~((wr && paddr == APB_EVT) ? pwdata[1:0] : 2'h0)) | set_e;
      irq <= |(evt & mask);
    end
  end
endmodule // fpx_core
`default_nettype wire

// ### verif/fpx_asserts.sv
// Checker watching the link between the core end and the device end.
`default_nettype none
module fpx_asserts
  import fpx_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        req,
  input wire logic [2:0]  op,
  input wire logic [15:0] addr,
  input wire logic        addr8,
  input wire logic [7:0]  wdata,
  input wire logic        done,
  input wire logic [7:0]  rdata,
  input wire logic        stall,
  input wire logic        ferr_reset
);
  // Shadow of the control register, so moves can be judged without the device body.
  logic [7:0] psc;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn) psc <= 8'h00;
    else if (req && op == OP_SFR_WR && addr[7:0] == ADDR_PSC) psc <= wdata;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held over one cycle");
  property p_sfr_lat; req && (op == OP_SFR_WR || op == OP_SFR_RD) |=> done; endproperty
  a_sfr_lat: assert property (p_sfr_lat) else $error("register access late");
  property p_ram_lat; req && op == OP_MOVE_RD && !addr8 && !addr[10] |=> done; endproperty
  a_ram_lat: assert property (p_ram_lat) else $error("user RAM read late");
  property p_fifo_lat; req && op == OP_MOVE_RD && !addr8 && addr[10] |=> !done [*4] ##1 done; endproperty
  a_fifo_lat: assert property (p_fifo_lat) else $error("FIFO region timing wrong");
  property p_stall_len; $rose(stall) |-> stall [*8]; endproperty
  a_stall_len: assert property (p_stall_len) else $error("flash stall too short");
  property p_ferr; ferr_reset |-> done; endproperty
  a_ferr: assert property (p_ferr) else $error("error reset without done");
  // Only user RAM writes answer at once; the FIFO region answers later by design.
  property p_ram_only; req && op == OP_MOVE_WR && !psc[BIT_WE] && !addr8 && !addr[10] |=> done && !stall; endproperty
  a_ram_only: assert property (p_ram_only) else $error("flash touched with write enable clear");
  property p_rdata_hold; !done |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without done");
endmodule // fpx_asserts
`default_nettype wire

// ### verif/flash_program_and_on_chip_data_ram_access_tb.sv
// Testbench joining both ends over the link and driving the core end over APB.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("FAIL %0t got %h", $time, a); end end
module flash_program_and_on_chip_data_ram_access_tb
  import fpx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, irq, supply_ok, err, i0, ferr_in, ferr_flag;
  logic [31:0] paddr, pwdata, prdata, rdat, ev;
  logic [7:0]  rd;
  logic [1:0]  lock;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  fpx_link_if fpx_link_if_i ();
  fpx_core fpx_core_i (.core_clk(core_clk), .resetn(resetn), .lnk(fpx_link_if_i.core), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  fpx_device fpx_device_i (.core_clk(core_clk), .resetn(resetn), .lnk(fpx_link_if_i.device),
    .supply_ok(supply_ok), .flash_error_reset_flag_in(ferr_in), .flash_error_reset_flag(ferr_flag),
    .lock_state_out(lock), .flash_busy());
  fpx_asserts fpx_asserts_i (.core_clk(core_clk), .resetn(resetn), .req(fpx_link_if_i.req),
    .op(fpx_link_if_i.op), .addr(fpx_link_if_i.addr), .addr8(fpx_link_if_i.addr8),
    .wdata(fpx_link_if_i.wdata), .done(fpx_link_if_i.done), .rdata(fpx_link_if_i.rdata),
    .stall(fpx_link_if_i.stall), .ferr_reset(fpx_link_if_i.ferr_reset));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The whole run needs under a thousand cycles; this ceiling only catches a hang.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  // An idle cycle closes each transfer, so no strobe is driven twice in one step.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic mv(input logic [2:0] o, input logic [15:0] a, input logic [7:0] d,
                    input logic a8 = 1'b0, input logic clr = 1'b1);
    apb(1'b1, APB_CTRL, {4'h0, a8, o, a, d});
    do apb(1'b0, APB_EVT, 32'h0); while (rdat[EVT_DONE] !== 1'b1);
    ev = rdat;
    apb(1'b0, APB_RDATA, 32'h0);
    rd = rdat[7:0];
    if (clr) apb(1'b1, APB_EVT, 32'h3);
  endtask
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (w) mv(OP_SFR_WR, {8'h00, a}, d);
    else mv(OP_SFR_RD, {8'h00, a}, d);
  endtask
  task automatic unlock();
    sfr(1'b1, ADDR_KEY, KEY_FIRST);
    sfr(1'b0, ADDR_KEY, 8'h00);
    `CHK(rd[1:0], LK_FIRST)
    sfr(1'b1, ADDR_KEY, KEY_SECOND);
    `CHK(lock, LK_OPEN)
  endtask
  task automatic t_regs();
    sfr(1'b0, ADDR_SCALE, 8'h00);
    `CHK(rd, RST_SCALE)
    sfr(1'b1, ADDR_SCALE, 8'h7F);
    sfr(1'b0, ADDR_SCALE, 8'h00);
    `CHK(rd, 8'h00)
    sfr(1'b1, ADDR_SCALE, 8'h80);
    sfr(1'b1, ADDR_PSC, 8'hFC);
    sfr(1'b0, ADDR_PSC, 8'h00);
    `CHK(rd, 8'h00)
    sfr(1'b0, ADDR_KEY, 8'h00);
    `CHK(rd[1:0], LK_LOCKED)
    apb(1'b0, 32'h0000_0020, 32'h0);
    `CHK(err, 1'b1)
    $display("t_regs finished");
  endtask
  task automatic t_ram();
    mv(OP_MOVE_WR, 16'h0055, 8'h11);
    mv(OP_MOVE_WR, 16'h0012, 8'h5A);
    mv(OP_MOVE_RD, 16'hF812, 8'h00);
    `CHK(rd, 8'h5A)
    mv(OP_MOVE_WR, 16'h0455, 8'hC3);
    mv(OP_MOVE_RD, 16'h0C55, 8'h00);
    `CHK(rd, 8'hC3)
    mv(OP_MOVE_RD, 16'h0055, 8'h00);
    `CHK(rd, 8'h11)
    sfr(1'b1, ADDR_PAGE, 8'hFB);
    sfr(1'b0, ADDR_PAGE, 8'h00);
    `CHK(rd, 8'h03)
    mv(OP_MOVE_WR, 16'h0334, 8'h96);
    mv(OP_MOVE_RD, 16'h0034, 8'h00, 1'b1);
    `CHK(rd, 8'h96)
    $display("t_ram finished");
  endtask
  // The erase pass must run first, so the program pass lands on an erased page.
  task automatic t_flash(input logic [7:0] ctl);
    mv(OP_MOVE_WR, 16'h0100, 8'h77);
    unlock();
    sfr(1'b1, ADDR_PSC, ctl);
    mv(OP_MOVE_WR, 16'h0100, 8'h3C);
    `CHK(lock, LK_LOCKED)
    `CHK(fpx_device_i.flash[14'h0100], (ctl[BIT_EE] ? 8'hFF : 8'h3C))
    `CHK(fpx_device_i.flash[14'h01FF], 8'hFF)
    sfr(1'b1, ADDR_PSC, 8'h00);
    mv(OP_MOVE_RD, 16'h0100, 8'h00);
    `CHK(rd, 8'h77)
    $display("t_flash finished");
  endtask
  task automatic t_irq();
    mv(OP_SFR_RD, {8'h00, ADDR_PSC}, 8'h00, 1'b0, 1'b0);
    apb(1'b1, APB_MASK, 32'h0);
    @(posedge core_clk);
    i0 = irq;
    apb(1'b1, APB_MASK, 32'h3);
    @(posedge core_clk);
    `CHK(i0, 1'b0)
    `CHK(irq, 1'b1)
    apb(1'b1, APB_EVT, 32'h3);
    @(posedge core_clk);
    `CHK(irq, 1'b0)
    $display("t_irq finished");
  endtask
  task automatic t_ferr();
    supply_ok <= 1'b0;
    unlock();
    sfr(1'b1, ADDR_PSC, 8'h01);
    mv(OP_MOVE_WR, 16'h0200, 8'h12);
    `CHK(ev[EVT_FERR], 1'b1)
    supply_ok <= 1'b1;
    sfr(1'b1, ADDR_KEY, 8'h11);
    `CHK(lock, LK_DEAD)
    sfr(1'b1, ADDR_KEY, KEY_FIRST);
    sfr(1'b1, ADDR_KEY, KEY_SECOND);
    `CHK(lock, LK_DEAD)
    $display("t_ferr finished");
  endtask
  // A mid-run reset must clear the dead lock and capture the error cause.
  task automatic t_reset();
    resetn <= 1'b0;
    ferr_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    `CHK(ferr_flag, 1'b1)
    `CHK(lock, LK_LOCKED)
    ferr_in <= 1'b0;
    sfr(1'b1, ADDR_PSC, 8'h01);
    mv(OP_MOVE_WR, 16'h0300, 8'h00);
    `CHK(lock, LK_DEAD)
    $display("t_reset finished");
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    supply_ok = 1'b1;
    ferr_in = 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_ram();
    t_flash(8'h03);
    t_flash(8'h01);
    t_irq();
    t_ferr();
    t_reset();
    test_done();
  end
endmodule // flash_program_and_on_chip_data_ram_access_tb
`default_nettype wire
